/* tb/stm_monitor_props.sv */
// Purpose: Port assertions of the supply monitor
// Assumes: ce_i dropped only while mask and sleep inputs hold
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module stm_monitor_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Watched ports
    input wire logic reg_we_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic mon_en_o,
    input wire stm_pkg::stm_cfg_s thr_cfg_o,
    input wire stm_pkg::stm_mv_t thr_mv_o,
    input wire logic [1:0] trx_sleep_i,
    input wire logic [1:0] irq_mask_i,
    input wire logic [1:0] irq_clr_i,
    input wire logic [1:0] irq_status_o,
    input wire logic [1:0] irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ****
    // Properties
    // ****
    property p_wr; reg_we_i && ce_i |=> thr_cfg_o == $past(reg_wdata_i[4:0]); endproperty
    a_wr: assert property (p_wr) else $error("cfg not taken");
    property p_rd; reg_rdata_o[4:0] == thr_cfg_o && reg_rdata_o[7:6] == 2'h0; endproperty
    a_rd: assert property (p_rd) else $error("read image wrong");
    property p_mv; thr_mv_o == (thr_cfg_o.range ? 12'h9F6 + 12'h04B * thr_cfg_o.code
        : 12'h6A4 + 12'h032 * thr_cfg_o.code); endproperty
    a_mv: assert property (p_mv) else $error("threshold mv wrong");
    property p_irq; irq_o == (irq_status_o & $past(irq_mask_i)); endproperty
    a_irq: assert property (p_irq) else $error("irq not status and mask");
    property p_off; &trx_sleep_i [*3] |-> !mon_en_o && !reg_rdata_o[5]; endproperty
    a_off: assert property (p_off) else $error("active in deep sleep");
    property p_drop; $rose(irq_status_o[0]) |-> $past(reg_rdata_o[5]) && !reg_rdata_o[5]; endproperty
    a_drop: assert property (p_drop) else $error("status without drop");
    property p_slp; $rose(irq_status_o[1]) |-> !$past(trx_sleep_i[1]); endproperty
    a_slp: assert property (p_slp) else $error("status while asleep");
    property p_hold; irq_status_o[0] && !irq_clr_i[0] |=> irq_status_o[0]; endproperty
    a_hold: assert property (p_hold) else $error("status lost");
    property p_clr; $fell(irq_clr_i[0]) && $stable(reg_rdata_o[5]) |-> !irq_status_o[0]; endproperty
    a_clr: assert property (p_clr) else $error("status not cleared");
endmodule
`default_nettype wire

/* tb/stm_monitor_tb_top.sv */
// Purpose: Self-checking bench of the supply monitor
// Assumes: Comparator modelled from the driven threshold
// Notes: ce_i dropped once for a frozen write; sup is the supply in mV
`timescale 1ns/1ps
`default_nettype none
module stm_monitor_tb_top;
    // ****
    // Signals
    // ****
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic reg_we_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic cmp_above_i = 1'b0;
    logic [1:0] trx_sleep_i = 2'h0;
    logic [1:0] irq_mask_i = 2'h0;
    logic [1:0] irq_clr_i = 2'h0;
    logic [7:0] reg_rdata_o;
    logic mon_en_o;
    stm_pkg::stm_cfg_s thr_cfg_o;
    stm_pkg::stm_mv_t thr_mv_o;
    logic [1:0] irq_status_o;
    logic [1:0] irq_o;
    logic [11:0] sup = 12'hFA0;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    stm_monitor DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_we_i(reg_we_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .cmp_above_i(cmp_above_i),
        .mon_en_o(mon_en_o), .thr_cfg_o(thr_cfg_o), .thr_mv_o(thr_mv_o), .trx_sleep_i(trx_sleep_i),
        .irq_mask_i(irq_mask_i), .irq_clr_i(irq_clr_i), .irq_status_o(irq_status_o), .irq_o(irq_o));
    function automatic stm_pkg::stm_mv_t thr(input logic [4:0] c);
        return c[4] ? 12'h9F6 + 12'h04B * c[3:0] : 12'h6A4 + 12'h032 * c[3:0];
    endfunction
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // Analog side follows the driven threshold one edge late
    always @(posedge clk_i) cmp_above_i <= sup > thr(thr_cfg_o);
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            final_report;
        end
    end
    // ****
    // Tasks
    // ****
    task automatic cy(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %0t %h %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        cy(1);
    endtask
    task automatic drv(input logic [11:0] s, input logic [1:0] sl, input logic [1:0] m, input int n);
        @(posedge clk_i);
        sup <= s;
        trx_sleep_i <= sl;
        irq_mask_i <= m;
        cy(n);
    endtask
    task automatic clr;
        @(posedge clk_i);
        irq_clr_i <= 2'h3;
        @(posedge clk_i);
        irq_clr_i <= 2'h0;
        cy(2);
        chk(irq_status_o, 2'h0);
    endtask
    task automatic rst;
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        cy(3);
        chk(reg_rdata_o, 8'h02);
        chk(thr_mv_o, 12'h708);
    endtask
    task automatic final_report;
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****
    // Sequence
    // ****
    initial
    begin
        rst;
        chk(mon_en_o, 1'b1);
        for (int i = 0; i < 32; i++)
        begin
            wr(8'hE0 | i[7:0]);
            chk(thr_mv_o, thr(i[4:0]));
            chk(reg_rdata_o[4:0], i[4:0]);
            chk(thr_cfg_o, i[4:0]);
        end
        // Clock enable low must freeze the register against a write
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(8'h05);
        chk(thr_cfg_o, 5'h1F);
        @(posedge clk_i);
        ce_i <= 1'b1;
        cy(110);
        chk(reg_rdata_o[5], 1'b1);
        drv(12'h3E8, 2'h2, 2'h1, 10);
        chk(reg_rdata_o[5], 1'b0);
        chk(irq_status_o, 2'h1);
        chk(irq_o, 2'h1);
        clr;
        drv(12'hFA0, 2'h0, 2'h2, 10);
        drv(12'h3E8, 2'h0, 2'h2, 10);
        chk(irq_status_o, 2'h3);
        chk(irq_o, 2'h2);
        clr;
        wr(8'h00);
        cy(110);
        chk(irq_status_o, 2'h0);
        drv(12'h7D0, 2'h0, 2'h2, 110);
        chk(reg_rdata_o[5], 1'b1);
        wr(8'h1F);
        cy(110);
        chk(reg_rdata_o[5], 1'b0);
        chk(irq_status_o, 2'h3);
        clr;
        drv(12'hFA0, 2'h0, 2'h2, 10);
        drv(12'hFA0, 2'h3, 2'h2, 5);
        chk(mon_en_o, 1'b0);
        chk(reg_rdata_o[5], 1'b0);
        drv(12'h3E8, 2'h3, 2'h2, 10);
        drv(12'h3E8, 2'h0, 2'h2, 110);
        chk(irq_status_o, 2'h0);
        rst;
        cy(110);
        chk(reg_rdata_o[5], 1'b0);
        chk(irq_status_o, 2'h0);
        final_report;
    end
endmodule
bind stm_monitor stm_monitor_props u_props (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .reg_we_i(reg_we_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .mon_en_o(mon_en_o),
    .thr_cfg_o(thr_cfg_o), .thr_mv_o(thr_mv_o), .trx_sleep_i(trx_sleep_i), .irq_mask_i(irq_mask_i),
    .irq_clr_i(irq_clr_i), .irq_status_o(irq_status_o), .irq_o(irq_o));
`default_nettype wire

/* verilog/stm_defines.svh */
// Purpose: Constants of the supply threshold monitor
// Assumes: 100 MHz digital clock
// Notes: Offsets, field positions, reset values and timing counts
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// ****************************************
// Control register fields
// ****************************************
`define STM_CODE_MSB 3
`define STM_CODE_LSB 0
`define STM_RANGE_BIT 4
`define STM_ABOVE_BIT 5
`define STM_CODE_RST 4'h2
`define STM_RANGE_RST 1'h0
`define STM_RANGE_LOW 1'h0
`define STM_RANGE_HIGH 1'h1

// ****************************************
// Threshold scale in millivolts
// ****************************************
`define STM_HIGH_BASE_MV 12'h9F6
`define STM_HIGH_STEP_MV 12'h04B
`define STM_LOW_BASE_MV 12'h6A4
`define STM_LOW_STEP_MV 12'h032

// ****************************************
// Timing
// ****************************************
`define STM_CLK_PERIOD_NS 10
`define STM_SETTLE_NS 1000
`define STM_SETTLE_CYC ((`STM_SETTLE_NS + `STM_CLK_PERIOD_NS - 1) / `STM_CLK_PERIOD_NS)

`endif

/* verilog/stm_monitor.sv */
// Purpose: Digital side of the supply threshold monitor
// Assumes: Comparator output arrives asynchronously from the analog side
// Notes: Control register reached through a plain write strobe and read port
`timescale 1ns/1ps
`default_nettype none

`include "stm_defines.svh"

module stm_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Control register access
    input wire logic reg_we_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Analog comparator and threshold drive
    input wire logic cmp_above_i,
    output logic mon_en_o,
    output stm_pkg::stm_cfg_s thr_cfg_o,
    output stm_pkg::stm_mv_t thr_mv_o,
    // Transceiver state and interrupts
    input wire logic [1:0] trx_sleep_i,
    input wire logic [1:0] irq_mask_i,
    input wire logic [1:0] irq_clr_i,
    output logic [1:0] irq_status_o,
    output logic [1:0] irq_o
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [7:0] SETTLE_CYC = 8'(`STM_SETTLE_CYC);

    stm_pkg::stm_top_s st_r;
    stm_pkg::stm_top_s st_nxt;
    stm_pkg::stm_cfg_s cfg_wr;
    stm_pkg::stm_cfg_s cfg_sel;
    stm_pkg::stm_mv_t mv_nxt;
    logic sync_above;
    logic active;
    logic settled;
    logic drop;

    // Read image of the control register
    function automatic logic [7:0] reg_image(input stm_pkg::stm_cfg_s cfg, input logic above);
        logic [7:0] img;
        img = 8'h00;
        img[`STM_CODE_MSB:`STM_CODE_LSB] = cfg.code;
        img[`STM_RANGE_BIT] = cfg.range;
        img[`STM_ABOVE_BIT] = above;
        return img;
    endfunction

    // ****************************************
    // Comparator synchroniser and scale
    // ****************************************
    assign cfg_wr = '{range: reg_wdata_i[`STM_RANGE_BIT], code: reg_wdata_i[`STM_CODE_MSB:`STM_CODE_LSB]};
    // Scale sees the next configuration, kept apart from the state copy to avoid a loop
    assign cfg_sel = reg_we_i ? cfg_wr : st_r.cfg;

    stm_sync3 u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .d_i(cmp_above_i),
        .q_o(sync_above)
    );

    stm_scale u_scale (
        .cfg_i(cfg_sel),
        .mv_o(mv_nxt)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        active = ~(trx_sleep_i[0] & trx_sleep_i[1]);
        settled = (st_r.settle == 8'h00);
        drop = 1'b0;

        st_nxt.mon_en = active;

        // A threshold change leaves the comparator stale for a while
        if (reg_we_i)
        begin
            st_nxt.cfg = cfg_wr;
            st_nxt.settle = SETTLE_CYC;
        end
        else if (!active)
        begin
            st_nxt.settle = SETTLE_CYC;
        end
        else if (!settled)
        begin
            st_nxt.settle = st_r.settle - 8'h01;
        end

        if (!active)
        begin
            // Forget history so waking up never looks like a drop
            st_nxt.above = 1'b0;
            st_nxt.prev_above = 1'b0;
        end
        else if (settled && !reg_we_i)
        begin
            st_nxt.above = sync_above;
            st_nxt.prev_above = sync_above;
            // Only a one-to-zero change counts, so a flag that never rose stays quiet
            drop = st_r.prev_above & ~sync_above;
        end

        // Set wins over a clear in the same cycle
        for (int i = 0; i < 2; i++)
        begin
            if (drop && !trx_sleep_i[i])
            begin
                st_nxt.status[i] = 1'b1;
            end
            else if (irq_clr_i[i])
            begin
                st_nxt.status[i] = 1'b0;
            end
        end

        st_nxt.irq = st_nxt.status & irq_mask_i;
        st_nxt.mv = mv_nxt;
        st_nxt.rdata = reg_image(st_nxt.cfg, st_nxt.above);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.cfg.code <= `STM_CODE_RST;
            st_r.cfg.range <= `STM_RANGE_RST;
            st_r.above <= 1'b0;
            st_r.prev_above <= 1'b0;
            st_r.settle <= SETTLE_CYC;
            st_r.status <= 2'h0;
            st_r.irq <= 2'h0;
            st_r.mon_en <= 1'b0;
            st_r.mv <= `STM_LOW_BASE_MV + 12'(2 * `STM_LOW_STEP_MV);
            st_r.rdata <= {3'h0, `STM_RANGE_RST, `STM_CODE_RST};
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_o = st_r.rdata;
    assign mon_en_o = st_r.mon_en;
    assign thr_cfg_o = st_r.cfg;
    assign thr_mv_o = st_r.mv;
    assign irq_status_o = st_r.status;
    assign irq_o = st_r.irq;

endmodule

`default_nettype wire

/* verilog/stm_pkg.sv */
// Purpose: Types of the supply threshold monitor
// Assumes: Nothing
// Notes: State of each clocked module is one packed struct, except the reset release flops
package stm_pkg;

    typedef logic [3:0] stm_code_t;
    typedef logic [11:0] stm_mv_t;

    // ****************************************
    // Configuration carried to the scale
    // ****************************************
    typedef struct packed {
        logic range;
        stm_code_t code;
    } stm_cfg_s;

    // ****************************************
    // Input synchroniser state
    // ****************************************
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
    } stm_sync_s;

    // ****************************************
    // Top state
    // ****************************************
    typedef struct packed {
        stm_cfg_s cfg;
        logic above;
        logic prev_above;
        logic [7:0] settle;
        logic [1:0] status;
        logic [1:0] irq;
        logic mon_en;
        stm_mv_t mv;
        logic [7:0] rdata;
    } stm_top_s;

endpackage

/* verilog/stm_scale.sv */
// Purpose: Threshold code to millivolt scale
// Assumes: Combinational, registered by the caller
// Notes: Linear map, base plus code times step
`timescale 1ns/1ps
`default_nettype none

`include "stm_defines.svh"

module stm_scale (
    // Configuration
    input wire stm_pkg::stm_cfg_s cfg_i,
    // Threshold
    output stm_pkg::stm_mv_t mv_o
);

    stm_pkg::stm_mv_t base;
    stm_pkg::stm_mv_t step;
    stm_pkg::stm_mv_t prod;

    always_comb
    begin
        if (cfg_i.range == `STM_RANGE_HIGH)
        begin
            base = `STM_HIGH_BASE_MV;
            step = `STM_HIGH_STEP_MV;
        end
        else
        begin
            base = `STM_LOW_BASE_MV;
            step = `STM_LOW_STEP_MV;
        end
        prod = step * {8'h00, cfg_i.code};
        mv_o = base + prod;
    end

endmodule

`default_nettype wire

/* verilog/stm_sync3.sv */
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Input from outside the clock domain
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module stm_sync3 (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Data
    input wire logic d_i,
    output logic q_o
);

    stm_pkg::stm_sync_s st_r;
    stm_pkg::stm_sync_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // First stage is never looked at, only the second and third
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.stable = st_r.s3;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.stable;

endmodule

`default_nettype wire
